// ### design/dbc_pkg.sv
// Constants, register map and state type of the DRAM bank controller
package dbc_pkg;
    // ==========================================================
    // Register map (byte offsets)
    localparam logic [7:0] OFS_BLK0 = 8'h00;
    localparam logic [7:0] OFS_TIM = 8'h10;
    localparam logic [7:0] OFS_SMM = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam int NUM_REGS = 8;
    localparam logic [2:0] IDX_TIM = 3'(OFS_TIM >> 2);
    localparam logic [2:0] IDX_SMM = 3'(OFS_SMM >> 2);
    localparam logic [2:0] IDX_CTRL = 3'(OFS_CTRL >> 2);
    localparam logic [2:0] IDX_STAT = 3'(OFS_STAT >> 2);
    // ==========================================================
    // Reset values and writable masks
    localparam logic [31:0] RST_BLK = 32'h0000_0000;
    localparam logic [31:0] RST_TIM = 32'h0000_7E7E;
    localparam logic [31:0] RST_SMM = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] MSK_BLK = 32'h0000_0FFF;
    localparam logic [31:0] MSK_TIM = 32'h0000_7F7F;
    localparam logic [31:0] MSK_SMM = 32'h0001_FFFF;
    localparam logic [31:0] MSK_CTRL = 32'h0000_0003;
    // ==========================================================
    // Field positions
    localparam int F_START = 0;
    localparam int F_DEPTH = 8;
    localparam int F_TWO = 10;
    localparam int F_EN = 11;
    localparam int F_RD = 0;
    localparam int F_WRB = 2;
    localparam int F_WS = 3;
    localparam int F_RCD = 4;
    localparam int F_REF = 5;
    localparam int F_PRE = 6;
    localparam int F_MST = 8;
    localparam int F_SMM_EN = 16;
    localparam int F_HI_PIN = 0;
    localparam int F_BUF_PIN = 1;
    // ==========================================================
    // Geometry
    localparam int NUM_BLOCKS = 4;
    localparam int NUM_BANKS = 8;
    localparam int NUM_LANES = 4;
    localparam int BURST_BEATS = 4;
    localparam int MB_SHIFT = 20;
    localparam int SMM_SHIFT = 16;
    // ==========================================================
    // Timing: T states, and ticks of aclk per T state
    localparam int TICKS_PER_T = 2;
    localparam int T_RD_LEAD = 3;
    localparam int T_RD_SUB = 2;
    localparam int T_WR_LEAD = 3;
    localparam int T_WR_SUB = 2;
    localparam int T_SW_LEN = 3;
    localparam int T_RCD = 2;
    localparam int T_REF = 3;
    localparam int T_PRE = 2;
    localparam int FAST_TRIM_TICKS = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        ST_IDLE, ST_MISS, ST_ROW, ST_BEAT, ST_PRE, ST_RF_CAS, ST_RF_RAS
    } dbc_state_e;
endpackage : dbc_pkg

// ### design/dbc_dram_ctrl.sv
// DRAM bank controller: decode, strobe timing, refresh and register file
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Behaviour
// - Eight row strobes, one per bank
// - Eight banks grouped as four blocks
// - Each bank selected by exactly one strobe
// - Four shared column strobes gate byte lanes
// - Per-block size, bank count and start
// - Bus masters use their own timing set
// - Burst reads 3-2-2-2, 4-3-3-3, 5-4-4-4
// - Single writes take one or two waits
// - Burst writes 3-2-2-2 or 4-3-3-3
// - Row-to-column delay 2/3, fast 1.5/2.5
// - Refresh row strobe width 3 or 4
// - Row precharge of 2 or 3 clocks
// - Depths 256K to 16M via muxing
// - Twelve row, ten column for 4M
// - 16M: 13/11 bits, extra bit pin
// - Optional data buffer control output
// - Device-select claimed cycles are not local
// - Write-backs accepted as burst writes
// - Hit-modified stalls master reads until cleared
// - SMM areas only reachable in SMM
// - Column-before-row refresh, other cycles wait
// - Done signals withheld during refresh
module dbc_dram_ctrl
    import dbc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_burst,
    input wire logic req_master,
    input wire logic req_smm,
    input wire logic req_ldev_n,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_be,
    input wire logic cpu_hit_modified_n,
    input wire logic refresh_req,
    output logic cycle_done_n,
    output logic burst_done_n,
    output logic mem_miss,
    output logic refresh_ack,
    output logic [NUM_BANKS-1:0] ras_n,
    output logic [NUM_LANES-1:0] cas_n,
    output logic mem_we_n,
    output logic [11:0] mem_addr,
    output logic mem_addr_high_bit,
    output logic buf_en_n,
    output logic buf_dir_rd
);
    // ==========================================================
    // Helpers
    // Block hit: {hit, upper bank}; address and start in 1 MB units
    function automatic logic [1:0] dbc_hit(input logic [11:0] a, input logic [31:0] c);
        logic [11:0] st;
        logic [11:0] off;
        logic [11:0] sz;
        st = {4'h0, c[F_START+:8]};
        off = a - st;
        sz = 12'h001 << {c[F_DEPTH+:2], 1'b0};
        dbc_hit[1] = c[F_EN] && (a >= st) && (off < (c[F_TWO] ? (sz << 1) : sz));
        dbc_hit[0] = off >= sz;
    endfunction : dbc_hit

    // Row or column address for a word address and device depth
    function automatic logic [12:0] dbc_mux(input logic [23:0] wa, input logic [1:0] d,
                                            input logic col);
        logic [4:0] cb;
        logic [4:0] rb;
        cb = (d == 2'd0) ? 5'd9 : (d == 2'd3) ? 5'd11 : 5'd10;
        rb = (d == 2'd0) ? 5'd9 : (d == 2'd1) ? 5'd10 : (d == 2'd2) ? 5'd12 : 5'd13;
        if (col) begin
            dbc_mux = 13'(wa & ~(24'hFF_FFFF << cb));
        end else begin
            dbc_mux = 13'((wa >> cb) & ~(24'hFF_FFFF << rb));
        end
    endfunction : dbc_mux

    dbc_state_e state;
    logic [31:0] cfg [NUM_REGS-1];
    logic [3:0] tick;
    logic [1:0] beat;
    logic ref_pend;
    logic cpu_hit_modified_n_s1, cpu_hit_modified_n_s2, cpu_hit_modified_n_s3, cpu_hit_modified_n_n_q;
    logic lat_wr, lat_burst;
    logic [3:0] lat_be;
    logic [23:0] lat_wa;
    logic [1:0] lat_depth;
    logic [2:0] lat_bank;
    logic [6:0] lat_tim;
    logic aw_h, w_h;
    logic [2:0] aw_idx;

    // ==========================================================
    // Decode of the pending request
    logic hit_any;
    logic [2:0] hit_bank;
    logic [1:0] hit_depth;
    logic [1:0] h;
    always_comb begin
        hit_any = 1'b0;
        hit_bank = 3'd0;
        hit_depth = 2'd0;
        h = 2'b00;
        // Descending scan so the lowest block wins an overlap
        for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
            h = dbc_hit(req_addr[31:MB_SHIFT], cfg[i]);
            if (h[1]) begin
                hit_any = 1'b1;
                hit_bank = {2'(i), h[0]};
                hit_depth = cfg[i][F_DEPTH+:2];
            end
        end
    end

    // Acceptance and locality
    logic cpu_hit_modified_n_act, smm_block, take, is_local, go_acc;
    assign cpu_hit_modified_n_act = !cpu_hit_modified_n_n_q;
    assign smm_block = cfg[IDX_SMM][F_SMM_EN] && !req_smm
        && (req_addr[31:SMM_SHIFT] == cfg[IDX_SMM][15:0]);
    // Master reads wait while the processor flushes a modified line
    assign take = (state == ST_IDLE) && !ref_pend && req_valid
        && !(cpu_hit_modified_n_act && req_master && !req_write);
    assign is_local = hit_any && req_ldev_n && !smm_block;
    assign go_acc = take && is_local;

    // ==========================================================
    // Timing derived from the latched set
    logic fast;
    logic [3:0] lead_t, sub_t, rcd_tk, first_end, beat_end, pre_end, ref_end;
    always_comb begin
        fast = !lat_wr && (lat_tim[F_RD+:2] == 2'd0);
        if (lat_wr) begin
            lead_t = lat_burst ? 4'(T_WR_LEAD + lat_tim[F_WRB])
                               : 4'(T_SW_LEN + lat_tim[F_WS]);
            sub_t = 4'(T_WR_SUB + lat_tim[F_WRB]);
        end else begin
            lead_t = 4'(T_RD_LEAD + lat_tim[F_RD+:2]);
            sub_t = 4'(T_RD_SUB + lat_tim[F_RD+:2]);
        end
        rcd_tk = 4'((T_RCD + lat_tim[F_RCD]) * TICKS_PER_T - (fast ? FAST_TRIM_TICKS : 0));
        first_end = (4'(lead_t * TICKS_PER_T) > 4'(rcd_tk + 4'd1))
            ? 4'(lead_t * TICKS_PER_T - 1) : 4'(rcd_tk + 4'd1);
        beat_end = (state == ST_ROW) ? first_end : 4'(sub_t * TICKS_PER_T - 1);
        pre_end = 4'((T_PRE + lat_tim[F_PRE]) * TICKS_PER_T - 1);
        ref_end = 4'((T_REF + lat_tim[F_REF]) * TICKS_PER_T - 1);
    end

    logic beat_fin, last_beat, acc_end, rf_end, rf_go;
    assign beat_fin = (state == ST_ROW || state == ST_BEAT) && (tick == beat_end);
    assign last_beat = !lat_burst || (beat == 2'(BURST_BEATS - 1));
    assign acc_end = beat_fin && last_beat;
    assign rf_end = (state == ST_RF_RAS) && (tick == ref_end);
    assign rf_go = (state == ST_IDLE) && ref_pend;

    // Column address of this and the next beat, line-wrapped in the low bits
    logic [1:0] next_beat;
    logic [12:0] col_now, col_next, row_req;
    assign next_beat = beat + 2'd1;
    assign col_now = dbc_mux({lat_wa[23:2], lat_wa[1:0] + beat}, lat_depth, 1'b1);
    assign col_next = dbc_mux({lat_wa[23:2], lat_wa[1:0] + next_beat}, lat_depth, 1'b1);
    assign row_req = dbc_mux(req_addr[25:2], hit_depth, 1'b0);

    // ==========================================================
    // Hit-modified pin synchroniser; a change counts once stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_hit_modified_n_s1 <= 1'b1;
            cpu_hit_modified_n_s2 <= 1'b1;
            cpu_hit_modified_n_s3 <= 1'b1;
            cpu_hit_modified_n_n_q <= 1'b1;
        end else if (ce) begin
            cpu_hit_modified_n_s1 <= cpu_hit_modified_n;
            cpu_hit_modified_n_s2 <= cpu_hit_modified_n_s1;
            cpu_hit_modified_n_s3 <= cpu_hit_modified_n_s2;
            if (cpu_hit_modified_n_s2 == cpu_hit_modified_n_s3) begin
                cpu_hit_modified_n_n_q <= cpu_hit_modified_n_s3;
            end
        end
    end

    // Refresh request; a new request beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_pend <= 1'b0;
        end else if (ce) begin
            ref_pend <= refresh_req || (ref_pend && !rf_go);
        end
    end

    // ==========================================================
    // Main sequencer; refresh wins over a waiting access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            tick <= 4'd0;
            beat <= 2'd0;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    tick <= 4'd0;
                    beat <= 2'd0;
                    if (rf_go) begin
                        state <= ST_RF_CAS;
                    end else if (take) begin
                        state <= is_local ? ST_ROW : ST_MISS;
                    end
                end
                ST_MISS: state <= ST_IDLE;
                ST_ROW, ST_BEAT: begin
                    if (beat_fin) begin
                        tick <= 4'd0;
                        beat <= next_beat;
                        state <= last_beat ? ST_PRE : ST_BEAT;
                    end else begin
                        tick <= tick + 4'd1;
                    end
                end
                ST_PRE: begin
                    tick <= tick + 4'd1;
                    if (tick == pre_end) begin
                        state <= ST_IDLE;
                    end
                end
                ST_RF_CAS: state <= ST_RF_RAS;
                ST_RF_RAS: begin
                    tick <= rf_end ? 4'd0 : tick + 4'd1;
                    if (rf_end) begin
                        state <= ST_PRE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Request capture; the timing set follows the requester type
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_wr <= 1'b0;
            lat_burst <= 1'b0;
            lat_be <= 4'h0;
            lat_wa <= 24'h00_0000;
            lat_depth <= 2'd0;
            lat_bank <= 3'd0;
            lat_tim <= RST_TIM[6:0];
        end else if (ce) begin
            if (rf_go) begin
                lat_tim <= cfg[IDX_TIM][6:0];
            end else if (go_acc) begin
                lat_wr <= req_write;
                lat_burst <= req_burst;
                lat_be <= req_be;
                lat_wa <= req_addr[25:2];
                lat_depth <= hit_depth;
                lat_bank <= hit_bank;
                lat_tim <= req_master ? cfg[IDX_TIM][F_MST+:7] : cfg[IDX_TIM][6:0];
            end
        end
    end

    // ==========================================================
    // DRAM strobes and address lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ras_n <= '1;
            cas_n <= '1;
            mem_we_n <= 1'b1;
            mem_addr <= 12'h000;
            mem_addr_high_bit <= 1'b0;
        end else if (ce) begin
            if (go_acc) begin
                ras_n <= ~(8'h01 << hit_bank);
                mem_we_n <= !req_write;
                mem_addr <= row_req[11:0];
                mem_addr_high_bit <= row_req[12] && cfg[IDX_CTRL][F_HI_PIN];
            end
            // Column address goes out one tick ahead of its strobe
            if (state == ST_ROW && tick == 4'(rcd_tk - 4'd2)) begin
                mem_addr <= col_now[11:0];
                mem_addr_high_bit <= col_now[12] && cfg[IDX_CTRL][F_HI_PIN];
            end
            if (state == ST_ROW && tick == 4'(rcd_tk - 4'd1)) begin
                cas_n <= lat_wr ? ~lat_be : '0;
            end
            if (state == ST_BEAT && tick == 4'd0) begin
                cas_n <= lat_wr ? ~lat_be : '0;
            end
            if (beat_fin && !last_beat) begin
                cas_n <= '1;
                mem_addr <= col_next[11:0];
                mem_addr_high_bit <= col_next[12] && cfg[IDX_CTRL][F_HI_PIN];
            end
            // Column-before-row refresh needs no address
            if (rf_go) begin
                cas_n <= '0;
            end
            if (state == ST_RF_CAS) begin
                ras_n <= '0;
            end
            if (acc_end || rf_end) begin
                ras_n <= '1;
                cas_n <= '1;
                mem_we_n <= 1'b1;
            end
        end
    end

    // Cycle answers; nothing completes while refresh owns the array
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycle_done_n <= 1'b1;
            burst_done_n <= 1'b1;
            mem_miss <= 1'b0;
            refresh_ack <= 1'b0;
            buf_en_n <= 1'b1;
            buf_dir_rd <= 1'b0;
        end else if (ce) begin
            cycle_done_n <= !acc_end;
            burst_done_n <= !(beat_fin && lat_burst);
            mem_miss <= take && !is_local;
            refresh_ack <= rf_go;
            if (go_acc && cfg[IDX_CTRL][F_BUF_PIN]) begin
                buf_en_n <= 1'b0;
                buf_dir_rd <= !req_write;
            end else if (acc_end) begin
                buf_en_n <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave; address and data taken in either order
    logic wr_do, aw_ok;
    logic [2:0] ar_idx;
    logic [31:0] wr_msk, w_dat;
    logic [3:0] w_stb;
    assign wr_do = aw_h && w_h && !s_axi_bvalid;
    assign wr_msk = dbc_msk(aw_idx);
    assign aw_ok = (aw_idx != IDX_STAT);
    assign ar_idx = s_axi_araddr[4:2];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_idx <= 3'd0;
            w_dat <= 32'h0000_0000;
            w_stb <= 4'h0;
            for (int i = 0; i < NUM_REGS - 1; i++) begin
                cfg[i] <= (i < NUM_BLOCKS) ? RST_BLK : (i == IDX_TIM) ? RST_TIM
                    : (i == IDX_SMM) ? RST_SMM : RST_CTRL;
            end
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_h <= 1'b1;
                s_axi_awready <= 1'b0;
                // Offsets beyond the map fold onto the status slot
                aw_idx <= (s_axi_awaddr[7:5] == 3'd0) ? s_axi_awaddr[4:2] : IDX_STAT;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_h <= 1'b1;
                // The master may move wdata once taken, so keep a copy
                w_dat <= s_axi_wdata;
                w_stb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_ok ? RESP_OKAY : RESP_SLVERR;
                for (int b = 0; b < 4; b++) begin
                    if (aw_ok && w_stb[b]) begin
                        cfg[aw_idx][8*b+:8] <= w_dat[8*b+:8] & wr_msk[8*b+:8];
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_h <= 1'b0;
                w_h <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Writable bits of a register slot
    function automatic logic [31:0] dbc_msk(input logic [2:0] idx);
        dbc_msk = (idx < 3'(NUM_BLOCKS)) ? MSK_BLK : (idx == IDX_TIM) ? MSK_TIM
            : (idx == IDX_SMM) ? MSK_SMM : MSK_CTRL;
    endfunction : dbc_msk

    // Read channel; status shows live sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (s_axi_araddr[7:5] == 3'd0) ? RESP_OKAY : RESP_SLVERR;
                if (s_axi_araddr[7:5] != 3'd0) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (ar_idx == IDX_STAT) begin
                    s_axi_rdata <= {24'h00_0000, cpu_hit_modified_n_act, ref_pend, lat_bank, 3'(state)};
                end else begin
                    s_axi_rdata <= cfg[ar_idx];
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks; a frozen clock enable pauses them
    logic [3:0] hi_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt <= 4'hF;
        end else if (ce) begin
            hi_cnt <= !(&ras_n) ? 4'h0 : (hi_cnt == 4'hF) ? 4'hF : hi_cnt + 4'h1;
        end
    end
    default clocking dbc_cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    AST_ONE_BANK: assert property ((state == ST_ROW || state == ST_BEAT) |-> $onehot(~ras_n))
        else $error("Access drives not exactly one row strobe");
    AST_BANK_SEL: assert property (go_acc |=> ~ras_n == (8'h01 << $past(hit_bank)))
        else $error("Row strobe not on the decoded bank");
    AST_LANES: assert property ((state == ST_BEAT && lat_wr) |-> ((~cas_n & ~lat_be) == 4'h0))
        else $error("Column strobe on a disabled byte lane");
    AST_MST_SET: assert property ((go_acc && req_master) |=> lat_tim == $past(cfg[IDX_TIM][14:8]))
        else $error("Master access not using master timing set");
    AST_RCD: assert property ((state == ST_IDLE && go_acc) |=> (&cas_n)[*3])
        else $error("Column strobe too early after row strobe");
    AST_REF_WIDTH: assert property ((state == ST_RF_CAS) |=> (ras_n == 8'h00)[*6])
        else $error("Refresh row strobe too short");
    AST_PRECHARGE: assert property ((!(&ras_n) && $past(&ras_n)) |-> hi_cnt >= 4'd4)
        else $error("Row precharge too short");
    AST_CPU_HIT_MODIFIED_N: assert property ((state == ST_IDLE && !ref_pend && req_valid && cpu_hit_modified_n_act
        && req_master && !req_write) |=> state == ST_IDLE)
        else $error("Master read started during hit-modified");
    AST_SMM: assert property ((take && smm_block) |=> mem_miss && (&ras_n))
        else $error("SMM area reached outside SMM");
    AST_LDEV: assert property ((take && !req_ldev_n) |=> mem_miss ##1 (&ras_n))
        else $error("Claimed cycle treated as local");
    AST_REF_HOLD: assert property ((state == ST_RF_RAS) |=> cycle_done_n && burst_done_n)
        else $error("Done given during refresh");
    AST_BURST_LEN: assert property ((go_acc && req_burst) |-> ##[8:80] !cycle_done_n)
        else $error("Burst did not complete in time");
endmodule : dbc_dram_ctrl

// ### sim/dbc_dram_model.sv
// DRAM bank model that records which banks saw a row strobe
`timescale 1ns/100ps
module dbc_dram_model (
    input wire logic aclk,
    input wire logic clr,
    input wire logic [7:0] ras_n,
    input wire logic [3:0] cas_n,
    output logic [7:0] hit
);
    // ====
    // Sticky bank record; the bench clears it before each access
    always_ff @(posedge aclk) begin
        hit <= clr ? 8'h00 : (hit | ~ras_n);
    end
endmodule : dbc_dram_model

// ### sim/dbc_dram_ctrl_tb.sv
// Self-checking testbench of the DRAM bank controller
`timescale 1ns/100ps
module dbc_dram_ctrl_tb import dbc_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, clr = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ras_n, hit;
    logic [31:0] s_axi_wdata = 32'h0000_0000, req_addr = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, req_be = 4'hf, cas_n;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_burst = 1'b1, req_master = 1'b0, req_smm = 1'b0, req_ldev_n = 1'b1;
    logic cpu_hit_modified_n = 1'b1, refresh_req = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cycle_done_n, burst_done_n, mem_miss, refresh_ack, mem_we_n;
    logic mem_addr_high_bit, buf_en_n, buf_dir_rd;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] mem_addr;
    int num_errors = 0, compares = 0;
    dbc_dram_ctrl dut (.*);
    dbc_dram_model mdl (.aclk(aclk), .clr(clr), .ras_n(ras_n), .cas_n(cas_n), .hit(hit));
    // ====
    // Clock, reset and watchdog
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #(25 * 20000);
        num_errors++;
        finish_test;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            num_errors++;
        end
    endtask : chk
    // ====
    // Register bus master; holds each channel until its ready
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        @(posedge aclk);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
    endtask : rd
    // Burst access; g is the spacing of the last two beat pulses, n their count
    task acc(input logic [31:0] a, input logic m, input logic l, output int g, output int n,
             output logic x);
        int t0;
        clr <= 1'b1;
        @(posedge aclk);
        {clr, req_addr, req_master, req_ldev_n, req_valid} <= {1'b0, a, m, l, 1'b1};
        {g, n, x, t0} = 0;
        for (int i = 0; i < 300 && cycle_done_n === 1'b1 && mem_miss !== 1'b1; i++) begin
            @(posedge aclk);
            if (burst_done_n === 1'b0) begin
                n++;
                g = i - t0;
                t0 = i;
            end
            x = mem_miss;
        end
        req_valid <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : acc
    // ====
    // Scenarios
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd(OFS_TIM, d, r);
        chk(d, 32'h0000_7E7E);
        rd(8'h20, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(OFS_STAT, 32'h0000_0000, r);
        chk(r, RESP_SLVERR);
        $display("t_regs done");
    endtask : t_regs
    task t_map;
        int g, n;
        logic x;
        logic [1:0] r;
        wr(8'h04, 32'h0000_0D01, r); // Block 1: enabled, two 1M banks at 1 MB
        acc(32'h0010_0000, 1'b0, 1'b1, g, n, x);
        chk(hit, 8'h04);
        acc(32'h0050_0000, 1'b0, 1'b1, g, n, x);
        chk(hit, 8'h08);
        acc(32'h0000_0000, 1'b0, 1'b1, g, n, x);
        chk({x, hit}, 9'h100);
        acc(32'h0010_0000, 1'b0, 1'b0, g, n, x);
        chk({x, hit}, 9'h100);
        $display("t_map done");
    endtask : t_map
    task t_timing;
        int g, n;
        logic x;
        logic [1:0] r;
        for (int m = 0; m < 3; m++) begin
            wr(OFS_TIM, 32'h0000_7E7C | m, r);
            acc(32'h0010_0000, 1'b0, 1'b1, g, n, x);
            chk(n, 4);
            chk(g, (2 + m) * 2);
        end
        wr(OFS_TIM, 32'h0000_7E7C, r);
        acc(32'h0010_0000, 1'b1, 1'b1, g, n, x); // Master set stays at its reset 5-4-4-4 mode
        chk(g, 8);
        $display("t_timing done");
    endtask : t_timing
    task t_misc;
        int g, n;
        logic x;
        logic [1:0] r;
        cpu_hit_modified_n <= 1'b0;
        repeat (5) @(posedge aclk);
        acc(32'h0010_0000, 1'b1, 1'b1, g, n, x); // Master read stalls to the limit
        chk(n, 0);
        cpu_hit_modified_n <= 1'b1;
        acc(32'h0010_0000, 1'b1, 1'b1, g, n, x);
        chk(n, 4);
        wr(OFS_SMM, 32'h0001_0010, r); // Region at 1 MB, enabled
        acc(32'h0010_0000, 1'b0, 1'b1, g, n, x);
        chk({x, hit}, 9'h100);
        {req_smm, req_write, req_be} <= {2'b11, 4'h5};
        acc(32'h0010_0000, 1'b0, 1'b1, g, n, x); // Burst write, 4-3-3-3
        chk({x, hit}, 9'h004);
        chk(g, 6);
        chk(n, 4);
        $display("t_misc done");
    endtask : t_misc
    task t_ref;
        int w, k;
        {w, k} = 0;
        refresh_req <= 1'b1;
        @(posedge aclk);
        refresh_req <= 1'b0;
        repeat (40) begin
            @(posedge aclk);
            k += refresh_ack;
            if (ras_n === 8'h00 && cas_n === 4'h0) w++;
        end
        chk(k, 1);
        chk(w, 8);
        $display("t_ref done");
    endtask : t_ref
    task finish_test;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_map;
        t_timing;
        t_misc;
        t_ref;
        finish_test;
    end
endmodule : dbc_dram_ctrl_tb
